/* File: shared/stall_pkg.sv */
package stall_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_LEVEL  = 8'h04;
  localparam logic [7:0] OFF_WAIT   = 8'h08;
  localparam logic [7:0] OFF_RAMP   = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK   = 8'h14;
  localparam logic [7:0] OFF_STATE  = 8'h18;
  localparam logic [7:0] OFF_CTRL   = 8'h1C;

  // ---------------------------------------------------------------
  // Field layout of the response mode register
  // ---------------------------------------------------------------
  localparam int MODE_LSB      = 0;
  localparam int MODE_MSB      = 2;
  localparam int MAG_RATED_BIT = 3;
  localparam int FINAL_ERR_BIT = 4;
  localparam logic [2:0] MODE_OFF  = 3'h0;
  localparam logic [2:0] MODE_HOLD = 3'h1;
  localparam logic [2:0] MODE_SLIP = 3'h2;
  localparam logic [2:0] MODE_DC   = 3'h3;

  // Status / mask bits, control bits
  localparam int EV_DETECT   = 0;
  localparam int EV_WARN     = 1;
  localparam int EV_ERROR    = 2;
  localparam int EV_W        = 3;
  localparam int CTRL_ERRCLR = 0;

  // Reset values
  localparam logic [7:0]  RST_MODE  = 8'h00;
  localparam logic [31:0] RST_LEVEL = 32'h0000_0000;
  localparam logic [15:0] RST_WAIT  = 16'h0000;
  localparam logic [15:0] RST_RAMP  = 16'h0000;
  localparam logic [EV_W-1:0] RST_MASK = 3'h0;

  // Error status code of a blockade
  localparam logic [7:0] BLOCKADE_CODE = 8'h1D;

  // ---------------------------------------------------------------
  // Timing: wait and ramp times count in 10 ms steps
  // ---------------------------------------------------------------
  localparam int TICK_TIME_US = 10000;
  localparam int CLK_FREQ_MHZ = 40;
  localparam int TICK_CYCLES  = TICK_TIME_US * CLK_FREQ_MHZ;

  typedef enum {ST_MONITOR, ST_HOLD, ST_RAMP, ST_WARN, ST_ERROR} stall_state_t;
endpackage : stall_pkg

/* File: verif/speed_source.sv */
`timescale 1ns/1ps
`default_nettype none
// Far side stand-in: set value source, ramp generator and speed measurement
module speed_source #(
  parameter int STEP = 1000
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic signed [31:0] set_target,
  input  wire logic signed [31:0] act_target,
  output logic signed [31:0]      speed_set_value,
  output logic signed [31:0]      ramp_output_value,
  output logic signed [31:0]      actual_speed_value
);
  // ---------------------------------------------------------------
  // Ramp follows the set value a step per cycle, so arming lags set
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      speed_set_value    <= '0;
      ramp_output_value  <= '0;
      actual_speed_value <= '0;
    end else begin
      speed_set_value    <= set_target;
      actual_speed_value <= act_target;
      if (ramp_output_value < set_target - STEP) ramp_output_value <= ramp_output_value + STEP;
      else if (ramp_output_value > set_target + STEP) ramp_output_value <= ramp_output_value - STEP;
      else ramp_output_value <= set_target;
    end
  end
endmodule : speed_source
`default_nettype wire

/* File: verif/test_motor_stall_detector.sv */
`timescale 1ns/1ps
`default_nettype none
module test_motor_stall_detector;
  import stall_pkg::*;
  logic clk_sys, rst_n, reg_wr, reg_rd, rd_seen;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, rd_data_q, r;
  logic signed [31:0] set_t, act_t, sv, rv, av;
  logic modulation_off_q, hold_state_q, current_ramp_q, freq_zero_q, mag_rated_q;
  logic warning_out_q, blockade_error_q, irq_q;
  logic [15:0] ramp_left_q;
  logic [7:0] status_code_q;
  logic [31:0] exp_q[$];
  int errors, n_compared, i;

  motor_stall_detector #(.TICK_CYC(4)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .rd_data_q(rd_data_q), .speed_set_value(sv),
    .ramp_output_value(rv), .actual_speed_value(av), .modulation_off_q(modulation_off_q),
    .hold_state_q(hold_state_q), .current_ramp_q(current_ramp_q), .freq_zero_q(freq_zero_q),
    .mag_rated_q(mag_rated_q), .ramp_left_q(ramp_left_q), .warning_out_q(warning_out_q),
    .blockade_error_q(blockade_error_q), .status_code_q(status_code_q), .irq_q(irq_q));
  speed_source src_u (.clk_sys(clk_sys), .rst_n(rst_n), .set_target(set_t),
    .act_target(act_t), .speed_set_value(sv), .ramp_output_value(rv), .actual_speed_value(av));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // Expected read data is noted here, compared by the watcher below
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a; reg_rd <= 1'b1; exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask : rd
  // Bounded wait for a level; a miss shows up in the checks that follow
  task wait_hi(input int which);
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      #1;
      if (which == 0 && status_code_q === BLOCKADE_CODE) break;
      if (which == 1 && blockade_error_q === 1'b1) break;
      if (which == 2 && warning_out_q === 1'b1) break;
    end
  endtask : wait_hi
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task drive(input int s, input int a);
    @(posedge clk_sys);
    set_t <= s; act_t <= a;
  endtask : drive
  task done(input string nm);
    $display("test %s finished", nm);
  endtask : done
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // Read watcher: read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_seen && exp_q.size() > 0) check("read data", rd_data_q, exp_q.pop_front());
    rd_seen <= reg_rd;
  end

  initial begin
    #(25 * 20000);
    errors++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; rd_seen = 1'b0;
    reg_addr = 8'h00; reg_wdata = 32'h0; set_t = 0; act_t = 0;
    errors = 0; n_compared = 0;
    void'($urandom(32'h70576398));
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Reset values and an unmapped place
    cyc(2);
    check("error out", blockade_error_q, 1'b0);
    rd(OFF_MODE, 32'h0);
    rd(OFF_LEVEL, 32'h0);
    rd(OFF_WAIT, 32'h0);
    rd(OFF_RAMP, 32'h0);
    rd(OFF_MASK, 32'h0);
    rd(8'h20, 32'h0);
    done("reset");
    // Random programming read back while disarmed
    r = $urandom();
    wr(OFF_LEVEL, r); rd(OFF_LEVEL, r);
    r = {16'h0, 16'($urandom())};
    wr(OFF_WAIT, r); rd(OFF_WAIT, r);
    r = {16'h0, 16'($urandom())};
    wr(OFF_RAMP, r); rd(OFF_RAMP, r);
    r = {24'h0, 8'($urandom()) & 8'h1F};
    wr(OFF_MODE, r); rd(OFF_MODE, r);
    done("registers");
    // Mode off: a hard stall never leads to a blockade
    wr(OFF_MODE, 32'h0); wr(OFF_LEVEL, 1000); wr(OFF_WAIT, 1); wr(OFF_RAMP, 1);
    drive(5000, 100); cyc(60);
    check("code mode off", status_code_q, 8'h00);
    check("modulation mode off", modulation_off_q, 1'b0);
    done("mode off");
    // Stall interrupted by recovery and by disarming before the wait runs out
    // Wait time first: arming with the old wait of 1 could trigger at once
    wr(OFF_WAIT, 3); wr(OFF_MODE, 32'h12);
    repeat (3) begin
      drive(5000, 100); cyc(5);
      drive(5000, 2000); cyc(3);
      drive(0, 100); cyc(3);
    end
    check("code interrupted", status_code_q, 8'h00);
    done("timer clear");
    // Mode 2 with latched error and interrupt
    wr(OFF_WAIT, 1); wr(OFF_MASK, 32'h4); wr(OFF_STATUS, 32'h7);
    drive(5000, 100); wait_hi(0);
    check("ramp on", current_ramp_q, 1'b1);
    check("freq mode 2", freq_zero_q, 1'b0);
    check("ramp left", ramp_left_q, 16'h1);
    check("mag zero", mag_rated_q, 1'b0);
    wait_hi(1);
    check("modulation off", modulation_off_q, 1'b1);
    check("code", status_code_q, BLOCKADE_CODE);
    cyc(1);
    check("irq error", irq_q, 1'b1);
    rd(OFF_STATUS, 32'h5);
    rd(OFF_STATE, 32'h041D_0000);
    drive(0, 0); cyc(30);
    check("no auto reset", blockade_error_q, 1'b1);
    wr(OFF_STATUS, 32'h7); cyc(2);
    check("irq cleared", irq_q, 1'b0);
    wr(OFF_CTRL, 32'h1); cyc(3);
    check("error cleared", blockade_error_q, 1'b0);
    check("code cleared", status_code_q, 8'h00);
    done("mode 2 error");
    // Mode 3 with rated magnetizing and warning, left by a sign change
    wr(OFF_MODE, 32'h0B); wr(OFF_MASK, 32'h2);
    drive(5000, 100); wait_hi(0);
    check("freq zero", freq_zero_q, 1'b1);
    check("ramp mode 3", current_ramp_q, 1'b1);
    check("mag rated", mag_rated_q, 1'b1);
    wait_hi(2);
    check("warn mod off", modulation_off_q, 1'b1);
    check("warn no error", blockade_error_q, 1'b0);
    cyc(1);
    check("irq warn", irq_q, 1'b1);
    rd(OFF_STATUS, 32'h3);
    drive(-5000, -5000); cyc(4);
    check("warn gone", warning_out_q, 1'b0);
    wr(OFF_STATUS, 32'h7);
    drive(0, 0); cyc(10);
    done("mode 3 warning");
    // Mode 1 holds until the set value reaches zero, then errors
    wr(OFF_MODE, 32'h11);
    drive(5000, 100); wait_hi(0); cyc(20);
    check("hold", hold_state_q, 1'b1);
    check("hold no ramp", current_ramp_q, 1'b0);
    check("hold no error", blockade_error_q, 1'b0);
    drive(0, 100); wait_hi(1);
    check("hold then error", blockade_error_q, 1'b1);
    wr(OFF_CTRL, 32'h1); cyc(3);
    check("hold cleared", hold_state_q, 1'b0);
    done("mode 1 hold");
    tally_and_finish();
  end
endmodule : test_motor_stall_detector
`default_nettype wire

/* File: verilog/motor_stall_detector.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_stall_detector #(
  parameter int TICK_CYC = stall_pkg::TICK_CYCLES
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              rd_data_q,
  input  wire logic signed [31:0]       speed_set_value,
  input  wire logic signed [31:0]       ramp_output_value,
  input  wire logic signed [31:0]       actual_speed_value,
  output logic                          modulation_off_q,
  output logic                          hold_state_q,
  output logic                          current_ramp_q,
  output logic                          freq_zero_q,
  output logic                          mag_rated_q,
  output logic      [15:0]              ramp_left_q,
  output logic                          warning_out_q,
  output logic                          blockade_error_q,
  output logic      [7:0]               status_code_q,
  output logic                          irq_q
);
  import stall_pkg::*;

  // ---------------------------------------------------------------
  // Registers and internal state
  // ---------------------------------------------------------------
  logic [7:0]      mode_q;
  logic [31:0]     level_q;
  logic [15:0]     wait_q;
  logic [15:0]     ramp_q;
  logic [EV_W-1:0] stat_q;
  logic [EV_W-1:0] mask_q;
  logic [31:0]     tick_cnt_q;
  logic            tick;
  logic [15:0]     timer_q;
  logic            set_sign_q;
  stall_state_t    state_q;
  stall_state_t    state_d;
  logic [2:0]      mode_sel;
  logic [31:0]     abs_set;
  logic [31:0]     abs_ramp;
  logic [31:0]     abs_act;
  logic            armed;
  logic            stall_cond;
  logic            blk_evt;
  logic            err_clr;
  logic [EV_W-1:0] ev;

  assign mode_sel = mode_q[MODE_MSB:MODE_LSB];
  assign err_clr  = reg_wr && (reg_addr == OFF_CTRL) && reg_wdata[CTRL_ERRCLR];

  // Magnitudes, so that both turning directions are supervised alike
  assign abs_set  = speed_set_value[31] ? 32'(-speed_set_value) : speed_set_value;
  assign abs_ramp = ramp_output_value[31] ? 32'(-ramp_output_value) : ramp_output_value;
  assign abs_act  = actual_speed_value[31] ? 32'(-actual_speed_value) : actual_speed_value;

  // ---------------------------------------------------------------
  // Stall condition
  // ---------------------------------------------------------------
  // Reserved modes 4..7 are treated like off
  assign armed = (mode_sel == MODE_HOLD || mode_sel == MODE_SLIP || mode_sel == MODE_DC)
                 && (abs_set > level_q) && (abs_ramp > level_q);
  // Ramp output kept high while actual speed lags below the level
  assign stall_cond = armed && (state_q == ST_MONITOR)
                      && (abs_act < level_q);
  assign blk_evt = stall_cond && (timer_q >= wait_q);

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Configuration words; narrow fields take the low data bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q  <= RST_MODE;
      level_q <= RST_LEVEL;
      wait_q  <= RST_WAIT;
      ramp_q  <= RST_RAMP;
      mask_q  <= RST_MASK;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_MODE:  mode_q  <= reg_wdata[7:0];
        OFF_LEVEL: level_q <= reg_wdata;
        OFF_WAIT:  wait_q  <= reg_wdata[15:0];
        OFF_RAMP:  ramp_q  <= reg_wdata[15:0];
        OFF_MASK:  mask_q  <= reg_wdata[EV_W-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------
  // One tick each 10 ms keeps the timers at 16 bits
  assign tick = (tick_cnt_q == 32'(TICK_CYC - 1));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // Stall waiting timer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= 16'h0000;
    end else if (!stall_cond) begin
      timer_q <= 16'h0000;
    end else if (tick && timer_q < wait_q) begin
      timer_q <= timer_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Blockade response sequence
  // ---------------------------------------------------------------
  // Final action once the response is done
  function automatic stall_state_t final_state(input logic err_sel);
    final_state = err_sel ? ST_ERROR : ST_WARN;
  endfunction : final_state

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_MONITOR: begin
        if (blk_evt) begin
          if (mode_sel == MODE_HOLD) begin
            state_d = ST_HOLD;
          end else begin
            state_d = ST_RAMP;
          end
        end
      end
      ST_HOLD: begin
        if (speed_set_value == 32'sh0) begin
          state_d = final_state(mode_q[FINAL_ERR_BIT]);
        end
      end
      ST_RAMP: begin
        if (ramp_left_q == 16'h0000 && tick) begin
          state_d = final_state(mode_q[FINAL_ERR_BIT]);
        end
      end
      ST_WARN: begin
        if (speed_set_value == 32'sh0 || speed_set_value[31] != set_sign_q) begin
          state_d = ST_MONITOR;
        end
      end
      ST_ERROR: begin
        // Only a software clear leaves; nothing resets it on its own
        if (err_clr) begin
          state_d = ST_MONITOR;
        end
      end
      default: state_d = ST_MONITOR;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_MONITOR;
    end else begin
      state_q <= state_d;
    end
  end

  // Sign of the set value at the blockade, for the warning release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      set_sign_q <= 1'b0;
    end else if (blk_evt) begin
      set_sign_q <= speed_set_value[31];
    end
  end

  // Remaining ramp time, reloaded at each blockade
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ramp_left_q <= 16'h0000;
    end else if (blk_evt) begin
      ramp_left_q <= ramp_q;
    end else if (state_q == ST_RAMP && tick && ramp_left_q != 16'h0000) begin
      ramp_left_q <= ramp_left_q - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Drive commands towards current control and modulation
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_state_q     <= 1'b0;
      current_ramp_q   <= 1'b0;
      freq_zero_q      <= 1'b0;
      mag_rated_q      <= 1'b0;
      modulation_off_q <= 1'b0;
      warning_out_q    <= 1'b0;
      blockade_error_q <= 1'b0;
    end else begin
      hold_state_q     <= (state_d == ST_HOLD);
      current_ramp_q   <= (state_d == ST_RAMP);
      freq_zero_q      <= (state_d == ST_RAMP) && (mode_sel == MODE_DC);
      mag_rated_q      <= mode_q[MAG_RATED_BIT];
      modulation_off_q <= (state_d == ST_WARN) || (state_d == ST_ERROR);
      warning_out_q    <= (state_d == ST_WARN);
      blockade_error_q <= (state_d == ST_ERROR);
    end
  end

  // Status code stays until the sequence returns to monitoring
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_code_q <= 8'h00;
    end else if (blk_evt) begin
      status_code_q <= BLOCKADE_CODE;
    end else if (state_d == ST_MONITOR) begin
      status_code_q <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  assign ev[EV_DETECT] = blk_evt;
  assign ev[EV_WARN]   = (state_d == ST_WARN) && (state_q != ST_WARN);
  assign ev[EV_ERROR]  = (state_d == ST_ERROR) && (state_q != ST_ERROR);

  // Write one to clear; an event in the same cycle wins over the clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~((reg_wr && reg_addr == OFF_STATUS) ?
                 reg_wdata[EV_W-1:0] : {EV_W{1'b0}})) | ev;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // ---------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_MODE:   rd_data_q <= {24'h000000, mode_q};
        OFF_LEVEL:  rd_data_q <= level_q;
        OFF_WAIT:   rd_data_q <= {16'h0000, wait_q};
        OFF_RAMP:   rd_data_q <= {16'h0000, ramp_q};
        OFF_STATUS: rd_data_q <= {29'h0000_0000, stat_q};
        OFF_MASK:   rd_data_q <= {29'h0000_0000, mask_q};
        OFF_STATE:  rd_data_q <= {5'h00, 3'(state_q), status_code_q, timer_q};
        default:    rd_data_q <= 32'h0000_0000;
      endcase
    end else begin
      rd_data_q <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  mode_off_a: assert property ((mode_sel == MODE_OFF) |-> !blk_evt)
    else $error("blockade raised with detection off");
  // A running timer proves that all three speed comparisons held a cycle before
  arm_cond_a: assert property ((timer_q != 16'h0000) |->
    $past(abs_set > level_q && abs_ramp > level_q && abs_act < level_q))
    else $error("timer ran while not armed");
  timer_inc_a: assert property ((stall_cond && tick && timer_q < wait_q) |=>
    (timer_q == $past(timer_q) + 16'h0001))
    else $error("stall timer did not step");
  timer_clr_a: assert property (!stall_cond |=> (timer_q == 16'h0000))
    else $error("stall timer not cleared");
  trigger_code_a: assert property (blk_evt |=>
    (status_code_q == BLOCKADE_CODE) && (state_q != ST_MONITOR))
    else $error("blockade code missing after trigger");
  hold_keep_a: assert property (
    (state_q == ST_HOLD && speed_set_value != 32'sh0) |=> (state_q == ST_HOLD && hold_state_q))
    else $error("hold state left early");
  dc_freq_a: assert property ((blk_evt && mode_sel == MODE_DC) |=> freq_zero_q)
    else $error("frequency not forced to zero");
  slip_ramp_a: assert property ((blk_evt && mode_sel == MODE_SLIP) |=>
    (current_ramp_q && !freq_zero_q && !hold_state_q))
    else $error("slip ramp not started");
  ramp_step_a: assert property (
    (state_q == ST_RAMP && tick && ramp_left_q != 16'h0000)
    |=> (ramp_left_q == $past(ramp_left_q) - 16'h0001))
    else $error("ramp time did not count down");
  ramp_end_a: assert property (
    (state_q == ST_RAMP && ramp_left_q == 16'h0000 && tick)
    |=> (state_q == ST_ERROR || state_q == ST_WARN))
    else $error("ramp end ignored");
  warn_out_a: assert property ((state_q == ST_WARN) |-> warning_out_q && modulation_off_q)
    else $error("warning output missing");
  warn_rel_a: assert property ((state_q == ST_WARN && speed_set_value == 32'sh0) |=>
    !warning_out_q)
    else $error("warning kept at zero set value");
  // A clear in the next cycle is legal, so only one cycle is promised
  err_latch_a: assert property ((state_q == ST_ERROR && !err_clr) |=>
    (state_q == ST_ERROR && blockade_error_q))
    else $error("blockade error released without clear");
  mag_sel_a: assert property (##1 mag_rated_q == $past(mode_q[MAG_RATED_BIT]))
    else $error("magnetizing target wrong");

  // Main scenarios, for coverage
  trig_c: cover property (blk_evt ##[1:300] state_q == ST_RAMP);
  hold_c: cover property (state_q == ST_HOLD ##[1:300] state_q == ST_WARN);
  err_c:  cover property (state_q == ST_ERROR ##[1:300] state_q == ST_MONITOR);
  warn_c: cover property (state_q == ST_WARN ##[1:300] state_q == ST_MONITOR);
  dc_c:   cover property (freq_zero_q ##[1:300] warning_out_q);
endmodule : motor_stall_detector
`default_nettype wire
